// ===== hw/uhi_regs_map.vh
`ifndef UHI_REGS_MAP_VH
`define UHI_REGS_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UHI_OFF_DEBUG 8'hA0
`define UHI_OFF_VCTRL 8'hA4
`define UHI_OFF_EERR 8'hA8
`define UHI_OFF_EADDR 8'hAC
`define UHI_OFF_LINKEN 8'hB0
`define UHI_OFF_HCS 8'h04
`define UHI_OFF_HCC 8'h08
`define UHI_OFF_OERR 8'h98
`define UHI_OFF_OADDR 8'h9C
// ----------------------------------------
// debug register fields
// ----------------------------------------
`define UHI_DBG_HCS_WR 0
`define UHI_DBG_HCC_WR 1
`define UHI_DBG_SHORT 2
`define UHI_DBG_NAKFIX 4
`define UHI_DBG_NOSUSP 5
`define UHI_DBG_W 6
`define UHI_DBG_WMASK 6'h37
// ----------------------------------------
// vendor control fields
// ----------------------------------------
`define UHI_VC_BUSY 17
`define UHI_VC_PORT_HI 16
`define UHI_VC_PORT_LO 13
`define UHI_VC_LOAD 12
`define UHI_VC_VAL_HI 11
`define UHI_VC_VAL_LO 8
`define UHI_VC_STAT_HI 7
// ----------------------------------------
// error status fields
// ----------------------------------------
`define UHI_ES_FLAG 31
`define UHI_ES_BURST_HI 11
`define UHI_ES_BURST_LO 9
`define UHI_ES_EXP_HI 8
`define UHI_ES_EXP_LO 4
`define UHI_ES_DONE_HI 3
// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define UHI_HCS_RST 32'h00001116
`define UHI_HCC_RST 32'h0000A010
`define UHI_HCC_WMASK 32'h0002FFF7
`define UHI_VC_LOAD_RST 1'h1
`define UHI_VLOAD_CYC 4'h4
`endif

// ===== hw/uhi_err_cap.v
`default_nettype none
`include "uhi_regs_map.vh"
// error capture for one host side
module uhi_err_cap (
    input wire clk, // bus clock
    input wire rst_n, // async reset, active low
    input wire err, // master saw error response
    input wire [2:0] burst, // burst type of transfer
    input wire [4:0] exp_beats, // beats expected
    input wire [3:0] done_beats, // beats finished
    input wire [31:0] addr, // failing address
    input wire clr, // software writes flag 0
    output wire [31:0] status, // status word
    output wire [31:0] address // address word
);
    reg flag_r;
    reg [11:0] info_r;
    reg [31:0] addr_r;
    // ------------------------------------
    // capture; set wins over clear
    // ------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'h0;
            info_r <= 12'h000;
            addr_r <= 32'h00000000; // RL12
        end else if (err) begin
            flag_r <= 1'h1; // RL8
            info_r <= {burst, exp_beats, done_beats}; // RL9 RL10 RL11
            addr_r <= addr; // RL12
        end else if (clr) begin
            flag_r <= 1'h0; // RL8
        end
    end
    assign status = {flag_r, 19'h00000, info_r};
    assign address = addr_r;
endmodule
`default_nettype wire

// ===== hw/uhi_regs.v
// What this block does
// [RL1] debug bit 5 low: run/stop clear drives port suspend; high: wake port
// [RL2] debug bit 4 high disables NAK reload repair, low enables it
// [RL3] debug bit 2 high shortens enumeration timing, simulation only
// [RL4] debug bit 1 lets software write HCCPARAMS bits 17, 15:4, 2:0
// [RL5] debug bit 0 lets software write HCSPARAMS
// [RL6] vendor write sets busy bit 17 until the PHY access completes
// [RL7] port 16:13, nibble 11:8, load bit 12 low loads, status 7:0
// [RL8] bus error sets status bit 31; software writes 0 to clear
// [RL9] burst type of failing transfer kept in bits 11:9
// [RL10] expected beat count of failing burst kept in bits 8:4
// [RL11] beats completed before the error kept in bits 3:0
// [RL12] failing address latched in read-only register, resets to zero
// [RL13] full/low-speed side has own error status, address at 0x98, 0x9C
//
// Register access over AHB-Lite was left to the implementer.
`default_nettype none
`include "uhi_regs_map.vh"
module uhi_regs #(
    parameter LINK_EN = 32'h00000000 // serial link enable readback
) (
    input wire SYS_CLK, // bus clock, 10 MHz
    input wire RST_N, // async reset, active low
    input wire HSEL, // slave select
    input wire [31:0] HADDR, // byte address
    input wire [1:0] HTRANS, // transfer type
    input wire HWRITE, // write when high
    input wire [2:0] HSIZE, // transfer size
    input wire [31:0] HWDATA, // write data
    input wire HREADY, // bus ready
    output reg [31:0] HRDATA, // read data
    output reg HREADYOUT, // slave ready
    output reg HRESP, // always okay
    input wire RUN_STOP, // run/stop bit of command reg
    output reg PORT_SUSPEND, // port suspend request
    output reg PORT_WAKE, // resume request, one pulse
    output reg NAK_FIX_EN, // NAK reload repair enable
    output reg SHORT_ENUM, // shortened enumeration
    output reg [31:0] HCS_VALUE, // structural params
    output reg [31:0] HCC_VALUE, // capability params
    output reg [3:0] VCTRL_PORT, // target port
    output reg [3:0] VCTRL_VALUE, // vendor control nibble
    output reg VCTRL_LOAD_N, // load strobe, active low
    input wire [7:0] VENDOR_STATUS_VALUE_IN, // phy vendor status
    input wire E_ERR, // hs master error pulse
    input wire [2:0] E_BURST, // hs burst type
    input wire [4:0] E_EXP, // hs expected beats
    input wire [3:0] E_DONE, // hs completed beats
    input wire [31:0] E_ADDR, // hs failing address
    input wire O_ERR, // fs master error pulse
    input wire [2:0] O_BURST, // fs burst type
    input wire [4:0] O_EXP, // fs expected beats
    input wire [3:0] O_DONE, // fs completed beats
    input wire [31:0] O_ADDR // fs failing address
);
    reg [`UHI_DBG_W-1:0] dbg_r;
    reg [3:0] vport_r;
    reg [3:0] vval_r;
    reg vload_r;
    reg busy_r;
    reg [3:0] vcnt_r;
    reg [7:0] vstat_r;
    reg [7:0] vs1_r;
    reg [7:0] vs2_r;
    reg [7:0] vs3_r;
    reg run_d_r;
    reg wr_ph_r;
    reg [7:0] wad_r;
    reg [31:0] rdata_nxt;
    wire wr_go;
    wire [31:0] e_stat;
    wire [31:0] e_addr;
    wire [31:0] o_stat;
    wire [31:0] o_addr;
    wire e_clr;
    wire o_clr;

    // ------------------------------------
    // bus front end
    // ------------------------------------
    function sel_hit;
        input [7:0] a;
        input [7:0] off;
        begin
            sel_hit = (a == off);
        end
    endfunction

    // address phase latched for writes
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ph_r <= 1'h0;
            wad_r <= 8'h00;
            HREADYOUT <= 1'h1;
            HRESP <= 1'h0;
        end else begin
            wr_ph_r <= HSEL & HREADY & HTRANS[1] & HWRITE;
            if (HSEL & HREADY & HTRANS[1])
                wad_r <= HADDR[7:0];
            HREADYOUT <= 1'h1;
            HRESP <= 1'h0;
        end
    end
    assign wr_go = wr_ph_r;
    assign e_clr = wr_go & sel_hit(wad_r, `UHI_OFF_EERR)
        & ~HWDATA[`UHI_ES_FLAG];
    assign o_clr = wr_go & sel_hit(wad_r, `UHI_OFF_OERR)
        & ~HWDATA[`UHI_ES_FLAG];

    // ------------------------------------
    // read mux; unmapped reads zero
    // ------------------------------------
    always @* begin
        rdata_nxt = 32'h00000000;
        case (HADDR[7:0])
        `UHI_OFF_DEBUG: rdata_nxt = {26'h0000000, dbg_r};
        `UHI_OFF_VCTRL: rdata_nxt = {14'h0000, busy_r, vport_r,
            vload_r, vval_r, vstat_r}; // RL7
        `UHI_OFF_EERR: rdata_nxt = e_stat;
        `UHI_OFF_EADDR: rdata_nxt = e_addr;
        `UHI_OFF_LINKEN: rdata_nxt = LINK_EN;
        `UHI_OFF_HCS: rdata_nxt = HCS_VALUE;
        `UHI_OFF_HCC: rdata_nxt = HCC_VALUE;
        `UHI_OFF_OERR: rdata_nxt = o_stat; // RL13
        `UHI_OFF_OADDR: rdata_nxt = o_addr; // RL13
        default: rdata_nxt = 32'h00000000;
        endcase
    end

    // read data registered at address phase
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N)
            HRDATA <= 32'h00000000;
        else if (HSEL & HREADY & HTRANS[1] & ~HWRITE)
            HRDATA <= rdata_nxt;
    end

    // ------------------------------------
    // debug and capability registers
    // ------------------------------------
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dbg_r <= 6'h00;
            HCS_VALUE <= `UHI_HCS_RST;
            HCC_VALUE <= `UHI_HCC_RST;
        end else if (wr_go) begin
            if (sel_hit(wad_r, `UHI_OFF_DEBUG))
                dbg_r <= HWDATA[`UHI_DBG_W-1:0] & `UHI_DBG_WMASK; // bit 3 kept 0
            if (sel_hit(wad_r, `UHI_OFF_HCS) & dbg_r[`UHI_DBG_HCS_WR])
                HCS_VALUE <= HWDATA; // RL5
            if (sel_hit(wad_r, `UHI_OFF_HCC) & dbg_r[`UHI_DBG_HCC_WR])
                HCC_VALUE <= (HWDATA & `UHI_HCC_WMASK)
                    | (HCC_VALUE & ~`UHI_HCC_WMASK); // RL4
        end
    end

    // ------------------------------------
    // tuning outputs and auto suspend
    // ------------------------------------
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_d_r <= 1'h0;
            PORT_SUSPEND <= 1'h0;
            PORT_WAKE <= 1'h0;
            NAK_FIX_EN <= 1'h1;
            SHORT_ENUM <= 1'h0;
        end else begin
            run_d_r <= RUN_STOP;
            NAK_FIX_EN <= ~dbg_r[`UHI_DBG_NAKFIX]; // RL2
            SHORT_ENUM <= dbg_r[`UHI_DBG_SHORT]; // RL3
            PORT_WAKE <= 1'h0;
            if (run_d_r & ~RUN_STOP) begin
                if (dbg_r[`UHI_DBG_NOSUSP]) begin
                    PORT_SUSPEND <= 1'h0; // RL1
                    PORT_WAKE <= 1'h1; // RL1
                end else begin
                    PORT_SUSPEND <= 1'h1; // RL1
                end
            end else if (~run_d_r & RUN_STOP) begin
                PORT_SUSPEND <= 1'h0;
            end
        end
    end

    // ------------------------------------
    // phy status synchroniser
    // ------------------------------------
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            vs1_r <= 8'h00;
            vs2_r <= 8'h00;
            vs3_r <= 8'h00;
            vstat_r <= 8'h00;
        end else begin
            vs1_r <= VENDOR_STATUS_VALUE_IN;
            vs2_r <= vs1_r;
            vs3_r <= vs2_r;
            if (vs2_r == vs3_r)
                vstat_r <= vs3_r; // RL7
        end
    end

    // ------------------------------------
    // vendor control load sequence
    // ------------------------------------
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            vport_r <= 4'h0;
            vval_r <= 4'h0;
            vload_r <= `UHI_VC_LOAD_RST;
            busy_r <= 1'h0;
            vcnt_r <= 4'h0;
            VCTRL_PORT <= 4'h0;
            VCTRL_VALUE <= 4'h0;
            VCTRL_LOAD_N <= 1'h1;
        end else if (wr_go & sel_hit(wad_r, `UHI_OFF_VCTRL) & ~busy_r) begin
            vport_r <= HWDATA[`UHI_VC_PORT_HI:`UHI_VC_PORT_LO];
            vval_r <= HWDATA[`UHI_VC_VAL_HI:`UHI_VC_VAL_LO];
            vload_r <= HWDATA[`UHI_VC_LOAD];
            VCTRL_PORT <= HWDATA[`UHI_VC_PORT_HI:`UHI_VC_PORT_LO]; // RL7
            VCTRL_VALUE <= HWDATA[`UHI_VC_VAL_HI:`UHI_VC_VAL_LO]; // RL7
            VCTRL_LOAD_N <= HWDATA[`UHI_VC_LOAD]; // RL7
            busy_r <= 1'h1; // RL6
            vcnt_r <= `UHI_VLOAD_CYC;
        end else if (busy_r) begin
            if (vcnt_r == 4'h1) begin
                busy_r <= 1'h0; // RL6
                VCTRL_LOAD_N <= 1'h1;
                vload_r <= 1'h1;
            end
            vcnt_r <= vcnt_r - 4'h1;
        end
    end

    // ------------------------------------
    // error capture, both host sides
    // ------------------------------------
    uhi_err_cap u_ehci_err (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .err(E_ERR),
        .burst(E_BURST),
        .exp_beats(E_EXP),
        .done_beats(E_DONE),
        .addr(E_ADDR),
        .clr(e_clr),
        .status(e_stat),
        .address(e_addr)
    );

    uhi_err_cap u_ohci_err (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .err(O_ERR),
        .burst(O_BURST),
        .exp_beats(O_EXP),
        .done_beats(O_DONE),
        .addr(O_ADDR),
        .clr(o_clr),
        .status(o_stat),
        .address(o_addr)
    );
endmodule
`default_nettype wire

// ===== testbench/uhi_regs_monitor.sv
`default_nettype none
`include "uhi_regs_map.vh"
module uhi_regs_monitor (
    input wire SYS_CLK, // bus clock
    input wire RST_N, // reset, active low
    input wire HSEL, // select
    input wire [31:0] HADDR, // address
    input wire [1:0] HTRANS, // transfer type
    input wire HWRITE, // write
    input wire [31:0] HWDATA, // write data
    input wire HREADY, // bus ready
    input wire RUN_STOP, // run/stop
    input wire PORT_SUSPEND, // suspend
    input wire PORT_WAKE, // wake pulse
    input wire NAK_FIX_EN, // nak repair
    input wire SHORT_ENUM, // short enum
    input wire [31:0] HCS_VALUE, // struct params
    input wire [31:0] HCC_VALUE, // cap params
    input wire [3:0] VCTRL_PORT, // port
    input wire [3:0] VCTRL_VALUE, // nibble
    input wire VCTRL_LOAD_N // load strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic aw_r;
    logic [7:0] aa_r;
    logic [5:0] dbg_r;
    logic [2:0] vc_r;
    wire dw = aw_r && aa_r == `UHI_OFF_DEBUG;
    wire vw = aw_r && aa_r == `UHI_OFF_VCTRL && vc_r == 3'h0;
    wire hw = aw_r && aa_r == `UHI_OFF_HCS;
    wire cw = aw_r && aa_r == `UHI_OFF_HCC;
    // write decode, debug shadow, vendor busy count
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_r <= 1'b0;
            aa_r <= 8'h00;
            dbg_r <= 6'h00;
            vc_r <= 3'h0;
        end else begin
            aw_r <= HSEL && HREADY && HTRANS[1] && HWRITE;
            aa_r <= HADDR[7:0];
            if (dw)
                dbg_r <= HWDATA[5:0];
            if (vw)
                vc_r <= 3'h4;
            else if (vc_r != 3'h0)
                vc_r <= vc_r - 3'h1;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_load;
        !VCTRL_LOAD_N [*4] ##1 VCTRL_LOAD_N;
    endsequence
    // outputs follow the debug register one cycle after it is written
    property p_nak; dw |=> ##1 NAK_FIX_EN == !$past(HWDATA[4], 2);
    endproperty
    property p_short; dw |=> ##1 SHORT_ENUM == $past(HWDATA[2], 2);
    endproperty
    property p_susp; $fell(RUN_STOP) && !dbg_r[5] |=> PORT_SUSPEND;
    endproperty
    property p_wake; $fell(RUN_STOP) && dbg_r[5] |=> PORT_WAKE ##1 !PORT_WAKE;
    endproperty
    property p_hcs; hw && !dbg_r[0] |=> $stable(HCS_VALUE); endproperty
    property p_hcc; cw && dbg_r[1] |=> HCC_VALUE ==
        (($past(HCC_VALUE) & ~`UHI_HCC_WMASK) |
        ($past(HWDATA) & `UHI_HCC_WMASK)); endproperty
    property p_vset; vw |=> VCTRL_PORT == $past(HWDATA[16:13]) &&
        VCTRL_VALUE == $past(HWDATA[11:8]); endproperty
    property p_vload; vw && !HWDATA[12] |=> s_load; endproperty
    a_nak: assert property (p_nak) else $error("nak repair wrong");
    a_short: assert property (p_short) else $error("short enum wrong");
    a_susp: assert property (p_susp) else $error("no suspend");
    a_wake: assert property (p_wake) else $error("no wake pulse");
    a_hcs: assert property (p_hcs) else $error("hcs written");
    a_hcc: assert property (p_hcc) else $error("hcc mask wrong");
    a_vset: assert property (p_vset) else $error("vendor fields");
    a_vload: assert property (p_vload) else $error("load length");
endmodule
bind uhi_regs uhi_regs_monitor mon (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HWDATA(HWDATA), .HREADY(HREADY), .RUN_STOP(RUN_STOP),
    .PORT_SUSPEND(PORT_SUSPEND), .PORT_WAKE(PORT_WAKE),
    .NAK_FIX_EN(NAK_FIX_EN), .SHORT_ENUM(SHORT_ENUM),
    .HCS_VALUE(HCS_VALUE), .HCC_VALUE(HCC_VALUE),
    .VCTRL_PORT(VCTRL_PORT), .VCTRL_VALUE(VCTRL_VALUE),
    .VCTRL_LOAD_N(VCTRL_LOAD_N));
`default_nettype wire

// ===== testbench/uhi_far_model.sv
`default_nettype none
module uhi_far_model #(parameter int DLY = 2) (
    input wire logic clk, // bus clock
    input wire logic rst_n, // reset, active low
    input wire logic load_n, // vendor load strobe
    input wire logic [7:0] nxt, // port and nibble
    output logic [7:0] status, // vendor status
    output logic e_err = 1'b0, // hs error pulse
    output logic o_err = 1'b0, // fs error pulse
    output logic [2:0] burst = 3'h0, // burst type
    output logic [4:0] beats = 5'h0, // expected beats
    output logic [3:0] done = 4'h0, // finished beats
    output logic [31:0] addr = 32'h0 // failing address
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ld_r;
    logic [3:0] cnt_r;
    // status answers a load after DLY cycles
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_r <= 1'b1;
            cnt_r <= 4'h0;
            status <= 8'h00;
        end else begin
            ld_r <= load_n;
            if (ld_r && !load_n)
                cnt_r <= DLY[3:0];
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1)
                status <= nxt;
        end
    end
    // one error pulse, then addr and burst scrambled
    task automatic fire(input logic hs, input logic [2:0] b,
        input logic [4:0] x, input logic [3:0] d, input logic [31:0] a);
        burst <= b;
        beats <= x;
        done <= d;
        addr <= a;
        e_err <= hs;
        o_err <= !hs;
        @(posedge clk);
        e_err <= 1'b0;
        o_err <= 1'b0;
        addr <= ~a;
        burst <= ~b;
    endtask
endmodule
`default_nettype wire

// ===== testbench/uhi_regs_tb.sv
`default_nettype none
`include "uhi_regs_map.vh"
module uhi_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic run = 1'b0, hrdy, hresp, susp, wake, nakf, shrt, vld_n;
    logic e_err, o_err;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, brst;
    logic [3:0] vport, vval, dn;
    logic [4:0] bts;
    logic [7:0] vst, o;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hcs, hcc, ea, rv;
    logic [7:0] ra[10] = '{8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'h98, 8'h9C,
        8'h04, 8'h08, 8'h50, 8'hB0};
    logic [31:0] re[10] = '{32'h0, 32'h1000, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h1116, 32'hA010, 32'h0, 32'h0};
    int miscompares = 0, check_count = 0, cyc = 0;
    uhi_regs dut (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
        .HREADYOUT(hrdy), .HRESP(hresp), .RUN_STOP(run),
        .PORT_SUSPEND(susp), .PORT_WAKE(wake), .NAK_FIX_EN(nakf),
        .SHORT_ENUM(shrt), .HCS_VALUE(hcs), .HCC_VALUE(hcc),
        .VCTRL_PORT(vport), .VCTRL_VALUE(vval), .VCTRL_LOAD_N(vld_n),
        .VENDOR_STATUS_VALUE_IN(vst), .E_ERR(e_err), .E_BURST(brst), .E_EXP(bts),
        .E_DONE(dn), .E_ADDR(ea), .O_ERR(o_err), .O_BURST(brst),
        .O_EXP(bts), .O_DONE(dn), .O_ADDR(ea));
    uhi_far_model far (.clk(clk), .rst_n(rst_n), .load_n(vld_n),
        .nxt({vport, vval}), .status(vst), .e_err(e_err), .o_err(o_err),
        .burst(brst), .beats(bts), .done(dn), .addr(ea));
    // clock and hang limit
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one single transfer; read data lands in rv
    task automatic xf(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (w)
            hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rv = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xf(a, 1'b0, 32'h0);
        chk(rv, e);
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], re[i]);
        chk(hresp, 32'h0);
        chk({nakf, shrt}, 32'h2);
        xf(8'hA0, 1'b1, 32'h3F);
        rd(8'hA0, 32'h37);
        chk({nakf, shrt}, 32'h1);
        xf(8'h04, 1'b1, 32'hFFFFFFFF);
        xf(8'h08, 1'b1, 32'hFFFFFFFF);
        rd(8'h04, 32'hFFFFFFFF);
        rd(8'h08, 32'h0002FFF7);
        xf(8'hA0, 1'b1, 32'h0);
        xf(8'h04, 1'b1, 32'h0);
        xf(8'h08, 1'b1, 32'h0);
        rd(8'h04, 32'hFFFFFFFF);
        rd(8'h08, 32'h0002FFF7);
        xf(8'h50, 1'b1, 32'hFFFFFFFF);
        rd(8'h50, 32'h0);
        $display("register test end");
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        repeat (2) @(posedge clk);
        chk(susp, 1);
        run <= 1'b1;
        xf(8'hA0, 1'b1, 32'h20);
        run <= 1'b0;
        repeat (2) @(posedge clk);
        chk({susp, wake}, 32'h1);
        $display("suspend test end");
        xf(8'hA4, 1'b1, 32'h0000AA00);
        xf(8'hA4, 1'b0, 32'h0);
        chk(rv[17], 1);
        xf(8'hA4, 1'b1, 32'h00006500);
        for (int n = 0; n < 20 && rv[17] !== 1'b0; n++)
            xf(8'hA4, 1'b0, 32'h0);
        repeat (8) @(posedge clk);
        rd(8'hA4, 32'h0000BA5A);
        $display("vendor test end");
        for (int s = 0; s < 2; s++) begin
            o = s ? `UHI_OFF_OERR : `UHI_OFF_EERR;
            far.fire(!s, 3'h5, 5'h10, 4'h7, 32'h12345678);
            rd(o, 32'h80000B07);
            rd(o + 8'h4, 32'h12345678);
            xf(o, 1'b1, 32'h0);
            rd(o, 32'h00000B07);
            far.fire(!s, 3'h2, 5'h1F, 4'h0, 32'hFFFFFFFC);
            rd(o, 32'h800005F0);
        end
        $display("error test end");
        stop_test();
    end
endmodule
`default_nettype wire
